// ==== rtl/scs_alu.sv ====
// Execution stage for unsigned compare, right shifts and subtract.
// What this block does
// RQ1 - Immediate compare sign-extends the 16-bit immediate, then compares unsigned.
// RQ2 - Register unsigned compare: opcode 000000, function 101011, bits 10..6 zero.
// RQ3 - Register unsigned compare treats both sources as unsigned, writes destination.
// RQ4 - Compare result is 1 when first is smaller, else 0, zero-extended.
// RQ5 - Unsigned compares never raise integer overflow.
// RQ6 - Fixed arithmetic right shift by shift-amount field, filling with bit 31.
// RQ7 - Variable arithmetic right shift, function 000111, bits 10..6 zero, sign fill.
// RQ8 - Variable shifts use only the low five bits of the source register.
// RQ9 - Fixed logical right shift, function 000010, bits 25..21 zero, zero fill.
// RQ10 - Variable logical right shift, function 000110, bits 10..6 zero, zero fill.
// RQ11 - Superscalar no-operation is left-shift encoding, all registers zero, amount 1.
// RQ12 - Superscalar no-operation breaks issue before itself and issues alone.
// RQ13 - On single issue it acts as a plain no-operation taking a slot.
// RQ14 - Trapping subtract, function 100010, forms first source minus second.
// RQ15 - On overflow (bits 32 and 31 differ) no write, raise overflow.
// RQ16 - Non-trapping subtract, function 100011, same difference, never overflows.
// RQ17 - Non-trapping subtract always writes the modulo 32-bit difference.
// RQ18 - A shift count of zero passes the target register unchanged.
`timescale 1ns/10ps
module scs_alu
  import scs_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire scs_pkg::scs_issue_type     issue,
  output logic                            issue_break,
  output logic                            issue_alone_reg,
  output logic                            accepted,
  output scs_pkg::scs_writeback_type      writeback_reg,
  output logic                            overflow_exception_reg,
  output logic                            no_operation_reg
);

  typedef enum {
    OP_NONE,
    OP_SET_LESS_REG,
    OP_SET_LESS_IMM,
    OP_SRL_FIXED,
    OP_SRA_FIXED,
    OP_SRL_VAR,
    OP_SRA_VAR,
    OP_SUB_TRAP,
    OP_SUB_MOD,
    OP_SUPERSCALAR_NOP,
    OP_PLAIN_NOP
  } scs_op_type;

  // Right shift with selectable fill; shared by all four shift forms.
  function automatic logic [31:0] shift_right(
    input logic [31:0] value,
    input logic [4:0]  amount,
    input logic        arith
  );
    logic [63:0] extended;
    extended = {{32{arith & value[31]}}, value};
    shift_right = extended[amount +: 32];
  endfunction : shift_right

  logic [5:0]  opcode;
  logic [5:0]  funct;
  logic [4:0]  first_source_field;
  logic [4:0]  second_source_field;
  logic [4:0]  dest_field;
  logic [4:0]  shift_amount_field;
  logic [31:0] imm_extended;
  logic [32:0] difference;
  logic        sub_overflow;
  scs_op_type  op;

  assign opcode              = issue.instr[OPC_MSB:OPC_LSB];
  assign funct               = issue.instr[FN_MSB:FN_LSB];
  assign first_source_field  = issue.instr[FS_MSB:FS_LSB];
  assign second_source_field = issue.instr[SS_MSB:SS_LSB];
  assign dest_field          = issue.instr[DST_MSB:DST_LSB];
  assign shift_amount_field  = issue.instr[SA_MSB:SA_LSB];

  assign imm_extended = {{16{issue.instr[IMM_MSB]}},
                         issue.instr[IMM_MSB:0]}; // RQ1

  // Sign-extend both operands to 33 bits so overflow shows as bit 32 vs 31.
  assign difference = {issue.first_source[31], issue.first_source}
                    - {issue.second_source[31], issue.second_source}; // RQ14
  assign sub_overflow = difference[32] ^ difference[31]; // RQ15

  always_comb begin
    op = OP_NONE;
    if (issue.valid && opcode == OPC_SET_LESS_UNSIGNED_IMM) begin
      op = OP_SET_LESS_IMM; // RQ1
    end else if (issue.valid && opcode == OPC_REGISTER_FORMAT) begin
      case (funct)
        FN_SET_LESS_UNSIGNED_REG: begin
          if (shift_amount_field == FIELD_ZERO) begin
            op = OP_SET_LESS_REG; // RQ2
          end
        end
        FN_SHIFT_RIGHT_ARITH_FIXED: begin
          if (first_source_field == FIELD_ZERO) begin
            op = OP_SRA_FIXED; // RQ6
          end
        end
        FN_SHIFT_RIGHT_LOGIC_FIXED: begin
          if (first_source_field == FIELD_ZERO) begin
            op = OP_SRL_FIXED; // RQ9
          end
        end
        FN_SHIFT_RIGHT_ARITH_VAR: begin
          if (shift_amount_field == FIELD_ZERO) begin
            op = OP_SRA_VAR; // RQ7
          end
        end
        FN_SHIFT_RIGHT_LOGIC_VAR: begin
          if (shift_amount_field == FIELD_ZERO) begin
            op = OP_SRL_VAR; // RQ10
          end
        end
        FN_SUBTRACT_TRAP: begin
          if (shift_amount_field == FIELD_ZERO) begin
            op = OP_SUB_TRAP; // RQ14
          end
        end
        FN_SUBTRACT_MODULO: begin
          if (shift_amount_field == FIELD_ZERO) begin
            op = OP_SUB_MOD; // RQ16
          end
        end
        FN_SHIFT_LEFT_LOGIC_FIXED: begin
          // Only the register-zero idioms belong here; other left shifts
          // are handled elsewhere in the core.
          if (issue.instr[FS_MSB:DST_LSB] == 15'h0000) begin
            if (shift_amount_field == SUPERSCALAR_NOP_AMOUNT) begin
              op = OP_SUPERSCALAR_NOP; // RQ11
            end else if (shift_amount_field == FIELD_ZERO) begin
              op = OP_PLAIN_NOP;
            end
          end
        end
        default: begin
          op = OP_NONE;
        end
      endcase
    end
  end

  // The no-operation must not pair with its predecessor, so the issue
  // logic is told combinationally to close the current group.
  assign issue_break = (op == OP_SUPERSCALAR_NOP); // RQ12
  assign accepted    = (op != OP_NONE);

  scs_writeback_type wb_next;
  logic              overflow_next;

  always_comb begin
    wb_next.write_enable = 1'b0;
    wb_next.dest_index   = dest_field;
    wb_next.value        = RESULT_RESET;
    overflow_next        = 1'b0; // RQ5
    case (op)
      OP_SET_LESS_REG: begin
        wb_next.write_enable = 1'b1; // RQ3
        wb_next.value = {31'h0000_0000,
          issue.first_source < issue.second_source}; // RQ4
      end
      OP_SET_LESS_IMM: begin
        wb_next.write_enable = 1'b1;
        wb_next.dest_index   = second_source_field;
        wb_next.value = {31'h0000_0000,
          issue.first_source < imm_extended}; // RQ4
      end
      OP_SRA_FIXED: begin
        wb_next.write_enable = 1'b1;
        wb_next.value = shift_right(issue.second_source,
          shift_amount_field, 1'b1); // RQ18
      end
      OP_SRL_FIXED: begin
        wb_next.write_enable = 1'b1;
        wb_next.value = shift_right(issue.second_source,
          shift_amount_field, 1'b0); // RQ18
      end
      OP_SRA_VAR: begin
        wb_next.write_enable = 1'b1;
        wb_next.value = shift_right(issue.second_source,
          issue.first_source[4:0], 1'b1); // RQ8
      end
      OP_SRL_VAR: begin
        wb_next.write_enable = 1'b1;
        wb_next.value = shift_right(issue.second_source,
          issue.first_source[4:0], 1'b0); // RQ8
      end
      OP_SUB_TRAP: begin
        wb_next.write_enable = ~sub_overflow; // RQ15
        wb_next.value        = difference[31:0];
        overflow_next        = sub_overflow; // RQ15
      end
      OP_SUB_MOD: begin
        wb_next.write_enable = 1'b1; // RQ17
        wb_next.value        = difference[31:0]; // RQ16
      end
      default: begin
        wb_next.write_enable = 1'b0; // RQ13
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      writeback_reg <= '0;
    end else begin
      writeback_reg <= wb_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      overflow_exception_reg <= 1'b0;
    end else begin
      overflow_exception_reg <= overflow_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      issue_alone_reg  <= 1'b0;
      no_operation_reg <= 1'b0;
    end else begin
      issue_alone_reg  <= (op == OP_SUPERSCALAR_NOP); // RQ12
      no_operation_reg <= (op == OP_SUPERSCALAR_NOP)
                        | (op == OP_PLAIN_NOP); // RQ13
    end
  end

endmodule : scs_alu

// ==== rtl/scs_pkg.sv ====
// Package for the shift, compare and subtract datapath.
package scs_pkg;

  localparam int unsigned DATA_W = 32;

  localparam logic [5:0] OPC_REGISTER_FORMAT = 6'h00;
  localparam logic [5:0] OPC_SET_LESS_UNSIGNED_IMM = 6'h0B;

  localparam logic [5:0] FN_SHIFT_LEFT_LOGIC_FIXED = 6'h00;
  localparam logic [5:0] FN_SHIFT_RIGHT_LOGIC_FIXED = 6'h02;
  localparam logic [5:0] FN_SHIFT_RIGHT_ARITH_FIXED = 6'h03;
  localparam logic [5:0] FN_SHIFT_RIGHT_LOGIC_VAR = 6'h06;
  localparam logic [5:0] FN_SHIFT_RIGHT_ARITH_VAR = 6'h07;
  localparam logic [5:0] FN_SUBTRACT_TRAP = 6'h22;
  localparam logic [5:0] FN_SUBTRACT_MODULO = 6'h23;
  localparam logic [5:0] FN_SET_LESS_UNSIGNED_REG = 6'h2B;

  localparam logic [4:0] FIELD_ZERO = 5'h00;
  localparam logic [4:0] SUPERSCALAR_NOP_AMOUNT = 5'h01;

  localparam int unsigned OPC_MSB = 31;
  localparam int unsigned OPC_LSB = 26;
  localparam int unsigned FS_MSB = 25;
  localparam int unsigned FS_LSB = 21;
  localparam int unsigned SS_MSB = 20;
  localparam int unsigned SS_LSB = 16;
  localparam int unsigned DST_MSB = 15;
  localparam int unsigned DST_LSB = 11;
  localparam int unsigned SA_MSB = 10;
  localparam int unsigned SA_LSB = 6;
  localparam int unsigned FN_MSB = 5;
  localparam int unsigned FN_LSB = 0;
  localparam int unsigned IMM_MSB = 15;

  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] first_source;
    logic [31:0] second_source;
  } scs_issue_type;

  typedef struct packed {
    logic        write_enable;
    logic [4:0]  dest_index;
    logic [31:0] value;
  } scs_writeback_type;

endpackage : scs_pkg

// ==== test/scs_alu_monitor.sv ====
// Concurrent checks on the ports of the datapath.
`timescale 1ns/10ps
module scs_alu_monitor
  import scs_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  arst_n,
  input wire scs_pkg::scs_issue_type issue,
  input wire logic                  issue_break,
  input wire logic                  issue_alone_reg,
  input wire logic                  accepted,
  input wire scs_pkg::scs_writeback_type writeback_reg,
  input wire logic                  overflow_exception_reg,
  input wire logic                  no_operation_reg
);
  import scs_pkg::*;
  scs_issue_type prev_reg;
  logic          rf;
  logic          sa_z;
  logic [5:0]    fn;
  logic [32:0]   d;
  logic [31:0]   a;
  logic [31:0]   b;
  logic [31:0]   v;
  logic          we;
  assign rf = issue.valid && issue.instr[31:26] == OPC_REGISTER_FORMAT;
  assign sa_z = issue.instr[10:6] == FIELD_ZERO;
  assign fn = issue.instr[5:0];
  assign a = prev_reg.first_source;
  assign b = prev_reg.second_source;
  assign d = {a[31], a} - {b[31], b};
  assign v = writeback_reg.value;
  assign we = writeback_reg.write_enable;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= issue;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_pause_seen;
    issue.valid && issue.instr == 32'h0000_0040 && issue_break;
  endsequence
  sequence s_alone_next;
    issue_alone_reg && no_operation_reg && !we;
  endsequence
  a_pause_issue_alone: assert property (
    issue.valid && issue.instr == 32'h0000_0040 |-> s_pause_seen ##1
    s_alone_next) else $error("pause op misbehaved");
  a_sub_trap_check: assert property (rf && fn == FN_SUBTRACT_TRAP && sa_z |=>
    ovf_ok(d) && v == d[31:0]) else $error("trapping subtract wrong");
  a_sub_modulo_result: assert property (rf && fn == FN_SUBTRACT_MODULO && sa_z
    |=> we && !overflow_exception_reg && v == d[31:0])
    else $error("modulo subtract wrong");
  a_sra_fixed_fill: assert property (rf && fn == FN_SHIFT_RIGHT_ARITH_FIXED &&
    issue.instr[25:21] == FIELD_ZERO |=> we &&
    v == 32'($signed(b) >>> prev_reg.instr[10:6])) else $error("sra wrong");
  a_sra_var_fill: assert property (rf && fn == FN_SHIFT_RIGHT_ARITH_VAR && sa_z
    |=> we && v == 32'($signed(b) >>> a[4:0])) else $error("srav wrong");
  a_srl_var_fill: assert property (rf && fn == FN_SHIFT_RIGHT_LOGIC_VAR && sa_z
    |=> we && v == b >> a[4:0]) else $error("shift_right_logic_var wrong");
  a_set_less_unsigned_reg_reg_result: assert property (rf && fn == FN_SET_LESS_UNSIGNED_REG &&
    sa_z |=> we && !overflow_exception_reg && v == {31'h0, a < b})
    else $error("register compare wrong");
  a_set_less_unsigned_reg_imm_result: assert property (issue.valid &&
    issue.instr[31:26] == OPC_SET_LESS_UNSIGNED_IMM |=> we &&
    !overflow_exception_reg && writeback_reg.dest_index == prev_reg.instr[20:16]
    && v == {31'h0, a < {{16{prev_reg.instr[15]}}, prev_reg.instr[15:0]}})
    else $error("immediate compare wrong");
  function automatic logic ovf_ok(input logic [32:0] t);
    return overflow_exception_reg == (t[32] != t[31]) && we == (t[32] == t[31]);
  endfunction : ovf_ok
endmodule : scs_alu_monitor
bind scs_alu scs_alu_monitor mon (.clock, .arst_n, .issue, .issue_break,
  .issue_alone_reg, .accepted, .writeback_reg, .overflow_exception_reg,
  .no_operation_reg);

// ==== test/scs_pipe_model.sv ====
// Behavioural pipeline side that presents operations to the datapath.
`timescale 1ns/10ps
module scs_pipe_model
  import scs_pkg::*;
(
  output scs_pkg::scs_issue_type issue
);
  import scs_pkg::*;
  initial issue = '0;
  task send(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
    issue = '{1'b1, i, a, b};
  endtask : send
  // Released operands flip so stale values can never look valid by chance.
  task idle;
    issue = '{1'b0, ~issue.instr, ~issue.first_source, ~issue.second_source};
  endtask : idle
endmodule : scs_pipe_model

// ==== test/testbench.sv ====
// Self-checking bench for the shift, compare and subtract datapath.
`timescale 1ns/10ps
module testbench;
  import scs_pkg::*;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
  end end
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  scs_issue_type     issue;
  scs_writeback_type wb;
  logic              brk, alone, acc, ovf, no_operation, c_acc, c_brk;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  initial forever #2.5 clock = ~clock;
  scs_pipe_model pipe (.issue(issue));
  scs_alu uut (.clock(clock), .arst_n(arst_n), .issue(issue),
    .issue_break(brk), .issue_alone_reg(alone), .accepted(acc),
    .writeback_reg(wb), .overflow_exception_reg(ovf), .no_operation_reg(no_operation));
  function automatic logic [31:0] r(input logic [4:0] s, input logic [4:0] t,
    input logic [4:0] d, input logic [4:0] sa, input logic [5:0] f);
    return {OPC_REGISTER_FORMAT, s, t, d, sa, f};
  endfunction : r
  // Each call presents one op right after the previous one, so ops run back to back.
  task exec(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b);
    pipe.send(i, a, b);
    #1 c_acc = acc;
    c_brk = brk;
    @(negedge clock);
  endtask : exec
  task op(input logic [31:0] i, input logic [31:0] a, input logic [31:0] b,
    input logic w, input logic [31:0] v, input logic o);
    exec(i, a, b);
    `CHK(c_acc, 1'b1)
    `CHK(wb.write_enable, w)
    `CHK(wb.value, v)
    `CHK(ovf, o)
    `CHK(wb.dest_index, i[31:26] == OPC_SET_LESS_UNSIGNED_IMM ? i[20:16] : i[15:11])
  endtask : op
  task t_compare;
    op(r(1, 2, 3, 0, FN_SET_LESS_UNSIGNED_REG), 1, 32'hFFFFFFFF, 1, 1, 0);
    op(r(1, 2, 4, 0, FN_SET_LESS_UNSIGNED_REG), 32'hFFFFFFFF, 1, 1, 0, 0);
    op({OPC_SET_LESS_UNSIGNED_IMM, 10'h026, 16'h8000}, 32'h7FFFFFFF, 0, 1, 1, 0);
    op({OPC_SET_LESS_UNSIGNED_IMM, 10'h026, 16'h8000}, 32'hFFFF8000, 0, 1, 0, 0);
  endtask : t_compare
  task t_shift;
    op(r(0, 2, 5, 4, FN_SHIFT_RIGHT_ARITH_FIXED), 0, 32'h80000010, 1, 32'hF8000001, 0);
    op(r(0, 2, 5, 31, FN_SHIFT_RIGHT_ARITH_FIXED), 0, 32'h40000000, 1, 0, 0);
    op(r(0, 2, 5, 4, FN_SHIFT_RIGHT_LOGIC_FIXED), 0, 32'h80000010, 1, 32'h08000001, 0);
    op(r(1, 2, 5, 0, FN_SHIFT_RIGHT_ARITH_VAR), 32'hFFFFFFE4, 32'h80000010, 1, 32'hF8000001, 0);
    op(r(1, 2, 5, 0, FN_SHIFT_RIGHT_LOGIC_VAR), 32'hFFFFFFE4, 32'h80000010, 1, 32'h08000001, 0);
    op(r(1, 2, 5, 0, FN_SHIFT_RIGHT_LOGIC_VAR), 32'h20, 32'h80000010, 1, 32'h80000010, 0);
    op(r(0, 2, 5, 0, FN_SHIFT_RIGHT_ARITH_FIXED), 0, 32'h80000010, 1, 32'h80000010, 0);
  endtask : t_shift
  task t_subtract;
    op(r(1, 2, 7, 0, FN_SUBTRACT_TRAP), 32'h80000000, 1, 0, 32'h7FFFFFFF, 1);
    op(r(1, 2, 7, 0, FN_SUBTRACT_TRAP), 32'h7FFFFFFF, 32'hFFFFFFFF, 0, 32'h80000000, 1);
    op(r(1, 2, 7, 0, FN_SUBTRACT_TRAP), 5, 7, 1, 32'hFFFFFFFE, 0);
    op(r(1, 2, 7, 0, FN_SUBTRACT_MODULO), 32'h80000000, 1, 1, 32'h7FFFFFFF, 0);
  endtask : t_subtract
  task t_noop;
    exec(32'h00000040, 0, 0);
    `CHK(c_brk, 1'b1)
    `CHK(alone, 1'b1)
    `CHK(no_operation, 1'b1)
    exec(32'h00000000, 0, 0);
    `CHK(c_brk, 1'b0)
    `CHK(alone, 1'b0)
    `CHK(c_acc, 1'b1)
    `CHK(no_operation, 1'b1)
    `CHK(wb.write_enable, 1'b0)
  endtask : t_noop
  task t_refuse;
    exec(r(1, 2, 3, 1, FN_SUBTRACT_MODULO), 9, 1);
    `CHK(c_acc, 1'b0)
    `CHK(wb.write_enable, 1'b0)
    exec(r(1, 2, 3, 4, FN_SHIFT_RIGHT_LOGIC_FIXED), 0, 8);
    `CHK(c_acc, 1'b0)
  endtask : t_refuse
  task print_verdict;
    $display("mismatches %0d, checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  // The whole run needs well under a hundred cycles after reset.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(negedge clock);
    arst_n = 1'b1;
    t_compare;
    t_shift;
    t_subtract;
    t_noop;
    t_refuse;
    pipe.idle;
    @(negedge clock);
    print_verdict;
  end
endmodule : testbench
